// file: verilog/brx_defines.svh
// Purpose: shared constants for the bit-clear, branch and return execute block
// Assumes: one instruction cycle is four clk_in periods
// Notes: bus offsets are byte indices on the plain register port
//
// Summary of operation
// [RQ1] bit clear forces chosen register bit low
// [RQ2] access flag low picks access bank
// [RQ3] extended mode, low addresses use indexed offset
// [RQ4] branch on negative jumps when N set
// [RQ5] branch no overflow jumps when OV clear
// [RQ6] branch not zero jumps when Z clear
// [RQ7] target is branch address plus two plus 2n
// [RQ8] branch takes one cycle, two when taken
// [RQ9] interrupt return pops stack into PC
// [RQ10] interrupt return sets the level's global enable
// [RQ11] fast return restores W, flags, bank
// [RQ12] normal return leaves W, flags, bank alone
// [RQ13] returns never touch PC latch registers
// [RQ14] literal return loads W, flags untouched
// [RQ15] literal return pops PC, two cycles
// [RQ16] 21-bit table pointer, 8-bit table latch
// [RQ17] indexed offsets are 7 bits plus pointer
// [RQ18] four phases per instruction cycle
// [RQ19] status holds C, DC, Z, OV, N
// [RQ20] bit clear is one-cycle read-modify-write, no flags
// [RQ21] prefetched word discarded after branch or return
`ifndef BRX_DEFINES_SVH
`define BRX_DEFINES_SVH

// =====================================================================
// opcode fields
`define BRX_OP_BCF 4'h9
`define BRX_OP_BRA 4'hE
`define BRX_CC_NEG 4'h6
`define BRX_CC_NOV 4'h5
`define BRX_CC_NZ 4'h1
`define BRX_OP_INTERRUPT_RETURN_OP 15'h0008
`define BRX_OP_LITERAL_RETURN_OP 8'h0C
`define BRX_NOP 16'h0000
`define BRX_IDX_LIMIT 8'h5F
`define BRX_ACCESS_SPLIT 8'h60
`define BRX_PC_STEP 21'h000002

// =====================================================================
// status and enable bit positions
`define BRX_ST_C 0
`define BRX_ST_DC 1
`define BRX_ST_Z 2
`define BRX_ST_OV 3
`define BRX_ST_N 4
`define BRX_CTRL_EXT 0
`define BRX_CTRL_PRIO 1
`define BRX_IE_HIGH 7
`define BRX_IE_LOW 6

// =====================================================================
// reset values
`define BRX_RST_PC 21'h000000
`define BRX_RST_BYTE 8'h00
`define BRX_RST_STATUS 5'h00

// =====================================================================
// register port offsets
`define BRX_REG_CTRL 8'h00
`define BRX_REG_STATUS 8'h01
`define BRX_REG_WORK 8'h02
`define BRX_REG_BANK 8'h03
`define BRX_REG_INTEN 8'h04
`define BRX_REG_WSHAD 8'h05
`define BRX_REG_FSHAD 8'h06
`define BRX_REG_BSHAD 8'h07
`define BRX_REG_PCL 8'h08
`define BRX_REG_PCH 8'h09
`define BRX_REG_PCU 8'h0A
`define BRX_REG_LATH 8'h0B
`define BRX_REG_LATU 8'h0C
`define BRX_REG_TPL 8'h0D
`define BRX_REG_TPH 8'h0E
`define BRX_REG_TPU 8'h0F
`define BRX_REG_TLAT 8'h10
`define BRX_REG_IPL 8'h11
`define BRX_REG_IPH 8'h12

`endif

// file: verilog/brx_pkg.sv
// Purpose: types for the execute block
// Assumes: constants live in brx_defines.svh
// Notes: core state is one packed struct
`default_nettype none
package brx_pkg;

    // =================================================================
    // phase of the instruction cycle
    typedef enum logic [1:0] {
        PH_DECODE = 2'b00,
        PH_READ = 2'b01,
        PH_PROC = 2'b10,
        PH_WRITE = 2'b11
    } brx_phase_e;

    // =================================================================
    // carriers
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } brx_bus_req_s;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] wdata;
        logic we;
    } brx_mem_req_s;

    typedef struct packed {
        logic [20:0] pc;
        logic [20:0] ins_pc;
        logic [15:0] ins;
        logic flush;
        logic [7:0] working_reg;
        logic [4:0] status;
        logic [3:0] bank_select_reg;
        logic [7:0] inten;
        logic [7:0] ws;
        logic [4:0] flags_shadow;
        logic [3:0] bank_select_shadow;
        logic [7:0] pc_high_latch;
        logic [4:0] pc_upper_latch;
        logic [20:0] table_pointer;
        logic [7:0] table_latch;
        logic [11:0] iptr;
        logic [1:0] ctrl;
        logic pop;
        logic [7:0] rdata;
    } brx_core_s;

endpackage : brx_pkg
`default_nettype wire

// file: verilog/brx_phase_gen.sv
// Purpose: four-phase sequencer of the instruction cycle
// Assumes: clk_in is the oscillator
// Notes: phases run decode, read, process, write
`timescale 1ns/100ps
`default_nettype none
module brx_phase_gen (
    input wire logic clk_in,
    input wire logic resetn_in,
    output var brx_pkg::brx_phase_e phase_out
);
    import brx_pkg::*;

    typedef struct packed {
        brx_phase_e ph;
    } brx_ph_s;

    brx_ph_s s_r;
    brx_ph_s s_nxt;

    // step through the four quarters, every code is legal
    always_comb begin
        s_nxt = s_r;
        unique case (s_r.ph)
            PH_DECODE: s_nxt.ph = PH_READ; // [RQ18]
            PH_READ: s_nxt.ph = PH_PROC;
            PH_PROC: s_nxt.ph = PH_WRITE;
            PH_WRITE: s_nxt.ph = PH_DECODE;
        endcase
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s_r <= '{ph: PH_DECODE};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign phase_out = s_r.ph;
endmodule : brx_phase_gen
`default_nettype wire

// file: verilog/brx_regfile.sv
// Purpose: data register file, 4096 bytes
// Assumes: one write port, one read port
// Notes: read data come from a register one clock after the address
`timescale 1ns/100ps
`default_nettype none
module brx_regfile (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire brx_pkg::brx_mem_req_s req_in,
    output logic [7:0] rdata_out
);
    import brx_pkg::*;

    logic [7:0] mem [0:4095];
    logic [7:0] rdata_r;

    // storage carries no reset, contents are unknown after power up
    always_ff @(posedge clk_in) begin
        if (req_in.we) begin
            mem[req_in.addr] <= req_in.wdata;
        end
    end

    // registered read, old data on a same-address write
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= mem[req_in.addr];
        end
    end

    assign rdata_out = rdata_r;
endmodule : brx_regfile
`default_nettype wire

// file: verilog/brx_exec.sv
// Purpose: execute bit clear, conditional branches and both returns
// Assumes: program word and stack top are valid whenever the core samples them
// Notes: register port writes land first, the core's own update wins after
`include "brx_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module brx_exec (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire brx_pkg::brx_bus_req_s bus_req_in,
    output logic [7:0] bus_rdata_out,
    input wire logic [15:0] prog_data_in,
    output logic [20:0] prog_addr_out,
    input wire logic [20:0] stack_top_in,
    output logic stack_pop_out
);
    import brx_pkg::*;

    // =================================================================
    // state and sub-blocks
    brx_core_s s_r;
    brx_core_s s_nxt;
    brx_phase_e phase;
    brx_mem_req_s mem_req;
    logic [7:0] mem_rdata;

    brx_phase_gen u_phase (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .phase_out(phase)
    );

    brx_regfile u_rf (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .req_in(mem_req),
        .rdata_out(mem_rdata)
    );

    // =================================================================
    // decode of the latched instruction
    logic is_bcf;
    logic is_bra;
    logic is_interrupt_return_op;
    logic is_literal_return_op;
    logic [3:0] cc;
    logic br_taken;
    logic [20:0] br_target;
    logic [7:0] bit_mask;
    logic [7:0] f_addr;
    logic [11:0] file_addr;
    logic [7:0] rd_val;

    // indirect pointer plus a 7-bit offset
    function automatic logic [11:0] idx_addr(input logic [11:0] ptr, input logic [6:0] off);
        return ptr + {5'h00, off}; // [RQ17]
    endfunction : idx_addr

    assign is_bcf = s_r.ins[15:12] == `BRX_OP_BCF; // [RQ1]
    assign is_bra = s_r.ins[15:12] == `BRX_OP_BRA;
    assign is_interrupt_return_op = s_r.ins[15:1] == `BRX_OP_INTERRUPT_RETURN_OP; // [RQ9]
    assign is_literal_return_op = s_r.ins[15:8] == `BRX_OP_LITERAL_RETURN_OP; // [RQ14]
    assign cc = s_r.ins[11:8];
    assign f_addr = s_r.ins[7:0];
    assign bit_mask = 8'h01 << s_r.ins[11:9];

    // condition test on the flags, other 1110 codes fall through as no-ops
    always_comb begin
        br_taken = 1'b0;
        if (is_bra) begin
            case (cc)
                `BRX_CC_NEG: br_taken = s_r.status[`BRX_ST_N]; // [RQ4] [RQ19]
                `BRX_CC_NOV: br_taken = !s_r.status[`BRX_ST_OV]; // [RQ5]
                `BRX_CC_NZ: br_taken = !s_r.status[`BRX_ST_Z]; // [RQ6]
                default: br_taken = 1'b0;
            endcase
        end
    end

    // ins_pc is the branch address, so this is address + 2 + 2n
    assign br_target = s_r.ins_pc + `BRX_PC_STEP + {{12{s_r.ins[7]}}, s_r.ins[7:0], 1'b0}; // [RQ7]

    // operand address: bank, access bank or indexed literal offset
    always_comb begin
        if (s_r.ins[8]) begin
            file_addr = {s_r.bank_select_reg, f_addr}; // [RQ2]
        end else if (s_r.ctrl[`BRX_CTRL_EXT] && f_addr <= `BRX_IDX_LIMIT) begin
            file_addr = idx_addr(s_r.iptr, f_addr[6:0]); // [RQ3]
        end else if (f_addr < `BRX_ACCESS_SPLIT) begin
            file_addr = {4'h0, f_addr}; // [RQ2]
        end else begin
            file_addr = {4'hF, f_addr};
        end
    end

    // read in read phase, cleared byte written back in write phase
    always_comb begin
        mem_req.addr = file_addr;
        mem_req.we = (phase == PH_WRITE) && is_bcf; // [RQ20]
        mem_req.wdata = mem_rdata & ~bit_mask; // [RQ1]
    end

    // =================================================================
    // register port read mux
    always_comb begin
        case (bus_req_in.addr)
            `BRX_REG_CTRL: rd_val = {6'h00, s_r.ctrl};
            `BRX_REG_STATUS: rd_val = {3'h0, s_r.status};
            `BRX_REG_WORK: rd_val = s_r.working_reg;
            `BRX_REG_BANK: rd_val = {4'h0, s_r.bank_select_reg};
            `BRX_REG_INTEN: rd_val = s_r.inten;
            `BRX_REG_WSHAD: rd_val = s_r.ws;
            `BRX_REG_FSHAD: rd_val = {3'h0, s_r.flags_shadow};
            `BRX_REG_BSHAD: rd_val = {4'h0, s_r.bank_select_shadow};
            `BRX_REG_PCL: rd_val = s_r.pc[7:0];
            `BRX_REG_PCH: rd_val = s_r.pc[15:8];
            `BRX_REG_PCU: rd_val = {3'h0, s_r.pc[20:16]};
            `BRX_REG_LATH: rd_val = s_r.pc_high_latch;
            `BRX_REG_LATU: rd_val = {3'h0, s_r.pc_upper_latch};
            `BRX_REG_TPL: rd_val = s_r.table_pointer[7:0];
            `BRX_REG_TPH: rd_val = s_r.table_pointer[15:8];
            `BRX_REG_TPU: rd_val = {3'h0, s_r.table_pointer[20:16]};
            `BRX_REG_TLAT: rd_val = s_r.table_latch;
            `BRX_REG_IPL: rd_val = s_r.iptr[7:0];
            `BRX_REG_IPH: rd_val = {4'h0, s_r.iptr[11:8]};
            default: rd_val = 8'h00;
        endcase
    end

    // =================================================================
    // next state: port access first, then the instruction phases
    always_comb begin
        s_nxt = s_r;
        s_nxt.pop = 1'b0;
        s_nxt.rdata = 8'h00;
        if (bus_req_in.rd) begin
            s_nxt.rdata = rd_val;
        end
        if (bus_req_in.wr) begin
            case (bus_req_in.addr)
                `BRX_REG_CTRL: s_nxt.ctrl = bus_req_in.wdata[1:0];
                `BRX_REG_STATUS: s_nxt.status = bus_req_in.wdata[4:0];
                `BRX_REG_WORK: s_nxt.working_reg = bus_req_in.wdata;
                `BRX_REG_BANK: s_nxt.bank_select_reg = bus_req_in.wdata[3:0];
                `BRX_REG_INTEN: s_nxt.inten = bus_req_in.wdata;
                `BRX_REG_WSHAD: s_nxt.ws = bus_req_in.wdata;
                `BRX_REG_FSHAD: s_nxt.flags_shadow = bus_req_in.wdata[4:0];
                `BRX_REG_BSHAD: s_nxt.bank_select_shadow = bus_req_in.wdata[3:0];
                `BRX_REG_PCL: s_nxt.pc[7:0] = bus_req_in.wdata;
                `BRX_REG_PCH: s_nxt.pc[15:8] = bus_req_in.wdata;
                `BRX_REG_PCU: s_nxt.pc[20:16] = bus_req_in.wdata[4:0];
                `BRX_REG_LATH: s_nxt.pc_high_latch = bus_req_in.wdata;
                `BRX_REG_LATU: s_nxt.pc_upper_latch = bus_req_in.wdata[4:0];
                `BRX_REG_TPL: s_nxt.table_pointer[7:0] = bus_req_in.wdata;
                `BRX_REG_TPH: s_nxt.table_pointer[15:8] = bus_req_in.wdata;
                `BRX_REG_TPU: s_nxt.table_pointer[20:16] = bus_req_in.wdata[4:0]; // [RQ16]
                `BRX_REG_TLAT: s_nxt.table_latch = bus_req_in.wdata; // [RQ16]
                `BRX_REG_IPL: s_nxt.iptr[7:0] = bus_req_in.wdata;
                `BRX_REG_IPH: s_nxt.iptr[11:8] = bus_req_in.wdata[3:0];
                default: s_nxt.ctrl = s_r.ctrl;
            endcase
        end
        unique case (phase)
            PH_DECODE: begin
                if (s_r.flush) begin
                    // refetch slot: the stale prefetch is dropped as a no-op
                    s_nxt.ins = `BRX_NOP; // [RQ21] [RQ8]
                    s_nxt.flush = 1'b0;
                end else begin
                    s_nxt.ins = prog_data_in;
                    s_nxt.ins_pc = s_r.pc;
                    s_nxt.pc = s_r.pc + `BRX_PC_STEP;
                end
            end
            PH_READ, PH_PROC: begin
                s_nxt.flush = s_r.flush;
            end
            PH_WRITE: begin
                if (br_taken) begin
                    s_nxt.pc = br_target; // [RQ7]
                    s_nxt.flush = 1'b1; // [RQ8]
                end
                if (is_interrupt_return_op || is_literal_return_op) begin
                    // latches keep whatever software left in them
                    s_nxt.pc = stack_top_in; // [RQ9] [RQ15] [RQ13]
                    s_nxt.pop = 1'b1;
                    s_nxt.flush = 1'b1; // [RQ21]
                end
                if (is_literal_return_op) begin
                    s_nxt.working_reg = s_r.ins[7:0]; // [RQ14]
                end
                if (is_interrupt_return_op) begin
                    // without priorities the high enable is the single global enable
                    if (!s_r.ctrl[`BRX_CTRL_PRIO] || !s_r.inten[`BRX_IE_HIGH]) begin
                        s_nxt.inten[`BRX_IE_HIGH] = 1'b1; // [RQ10]
                    end else begin
                        s_nxt.inten[`BRX_IE_LOW] = 1'b1; // [RQ10]
                    end
                    if (s_r.ins[0]) begin
                        s_nxt.working_reg = s_r.ws; // [RQ11]
                        s_nxt.status = s_r.flags_shadow;
                        s_nxt.bank_select_reg = s_r.bank_select_shadow;
                    end
                end
            end
        endcase
    end

    // =================================================================
    // state register
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s_r <= '{pc: `BRX_RST_PC, ins_pc: `BRX_RST_PC, ins: `BRX_NOP, flush: 1'b0,
                     working_reg: `BRX_RST_BYTE, status: `BRX_RST_STATUS, bank_select_reg: 4'h0, inten: `BRX_RST_BYTE,
                     ws: `BRX_RST_BYTE, flags_shadow: `BRX_RST_STATUS, bank_select_shadow: 4'h0, pc_high_latch: `BRX_RST_BYTE,
                     pc_upper_latch: 5'h00, table_pointer: `BRX_RST_PC, table_latch: `BRX_RST_BYTE, iptr: 12'h000,
                     ctrl: 2'h0, pop: 1'b0, rdata: `BRX_RST_BYTE};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign bus_rdata_out = s_r.rdata;
    assign prog_addr_out = s_r.pc;
    assign stack_pop_out = s_r.pop;

    // =================================================================
    // checks
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!resetn_in);

    logic q4_core;
    assign q4_core = (phase == PH_WRITE) && !bus_req_in.wr;

    a_bcf_write: assert property ((phase == PH_WRITE) && is_bcf |->
        mem_req.we && ((mem_req.wdata & bit_mask) == 8'h00) &&
        ((mem_req.wdata | bit_mask) == (mem_rdata | bit_mask))) // [RQ1]
        else $error("bit clear wrote wrong byte");

    a_bcf_flags: assert property (q4_core && is_bcf |=> s_r.status == $past(s_r.status)) // [RQ20]
        else $error("bit clear changed flags");

    a_neg_target: assert property (q4_core && is_bra && cc == `BRX_CC_NEG && s_r.status[`BRX_ST_N]
        |=> prog_addr_out == $past(s_r.ins_pc) + 21'h000002 + {{12{$past(s_r.ins[7])}}, $past(s_r.ins[7:0]), 1'b0})
        else $error("negative branch target wrong"); // [RQ4]

    a_nov_skip: assert property (q4_core && is_bra && cc == `BRX_CC_NOV && s_r.status[`BRX_ST_OV]
        |=> !s_r.flush ##1 s_r.ins_pc == $past(s_r.pc, 2)) // [RQ5]
        else $error("no-overflow branch taken with overflow set");

    a_nz_take: assert property (q4_core && is_bra && cc == `BRX_CC_NZ && !s_r.status[`BRX_ST_Z]
        |=> s_r.flush) // [RQ6]
        else $error("not-zero branch not taken");

    a_taken_idle: assert property (s_r.flush && phase == PH_DECODE && !bus_req_in.wr
        |=> (s_r.ins == 16'h0000 && !mem_req.we) [*4]) // [RQ8]
        else $error("refetch slot was not idle");

    a_ret_pop: assert property (q4_core && (is_interrupt_return_op || is_literal_return_op)
        |=> stack_pop_out && prog_addr_out == $past(stack_top_in) && s_r.pc_high_latch == $past(s_r.pc_high_latch)
            && s_r.pc_upper_latch == $past(s_r.pc_upper_latch) && s_r.flush) // [RQ13]
        else $error("return did not pop the stack");

    a_literal_return_op_work: assert property (q4_core && is_literal_return_op
        |=> s_r.working_reg == $past(s_r.ins[7:0]) && s_r.status == $past(s_r.status)) // [RQ14]
        else $error("literal return wrong W or flags");

    a_fast_restore: assert property (q4_core && is_interrupt_return_op && s_r.ins[0]
        |=> s_r.working_reg == $past(s_r.ws) && s_r.status == $past(s_r.flags_shadow) && s_r.bank_select_reg == $past(s_r.bank_select_shadow))
        else $error("fast return did not restore shadows"); // [RQ11]

    a_slow_keep: assert property (q4_core && is_interrupt_return_op && !s_r.ins[0]
        |=> $stable(s_r.working_reg) && $stable(s_r.status) && $stable(s_r.bank_select_reg)) // [RQ12]
        else $error("normal return touched W, flags or bank");

    a_gie_set: assert property (q4_core && is_interrupt_return_op
        |=> s_r.inten[`BRX_IE_HIGH] || s_r.inten[`BRX_IE_LOW]) // [RQ10]
        else $error("interrupt return left enables clear");

    a_phase_walk: assert property (phase == PH_DECODE
        |=> phase == PH_READ ##1 phase == PH_PROC ##1 phase == PH_WRITE ##1 phase == PH_DECODE)
        else $error("phase sequence broken"); // [RQ18]

endmodule : brx_exec
`default_nettype wire

// file: dv/brx_prog_model.sv
// Purpose: program memory and return stack beside brx_exec
// Assumes: the word at prog_addr_in is presented combinationally
// Notes: the bench fills memory and stack through hierarchy
`timescale 1ns/100ps
`default_nettype none
module brx_prog_model (
    input wire logic clk_in,
    input wire logic [20:0] prog_addr_in,
    output logic [15:0] prog_data_out,
    input wire logic stack_pop_in,
    output logic [20:0] stack_top_out
);
    logic [15:0] mem [0:255];
    logic [20:0] stk [0:7];
    logic [2:0] sp = 3'h0;

    // =====
    // fetch: only 256 words decode, so far targets alias onto low words
    assign prog_data_out = mem[prog_addr_in[8:1]];
    // an empty stack shows a moving pattern, never a stale address
    assign stack_top_out = (sp == 3'h0) ? {prog_addr_in[19:0], 1'b1} : stk[sp - 3'h1];

    // pop on the core's one-cycle pulse
    always @(posedge clk_in) begin
        if (stack_pop_in && sp != 3'h0) begin
            sp <= sp - 3'h1;
        end
    end

    // empty memory reads as the no-op word
    task clear_all();
        for (int i = 0; i < 256; i++) begin
            mem[i] = 16'h0000;
        end
        sp = 3'h0;
    endtask : clear_all
endmodule : brx_prog_model
`default_nettype wire

// file: dv/test_brx_exec.sv
// Purpose: self-checking bench for brx_exec
// Assumes: bus reads answer one cycle after the strobe
// Notes: programs sit at 0x80 so the no-op run leaves time for setup
`timescale 1ns/100ps
`default_nettype none
module test_brx_exec;
    import brx_pkg::*;
    logic clk_in = 1'b0;
    logic resetn_in = 1'b0;
    brx_bus_req_s bus_req = '0;
    logic [7:0] bus_rdata;
    logic [15:0] prog_data;
    logic [20:0] prog_addr;
    logic [20:0] stack_top;
    logic stack_pop;
    int n_mismatch = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [7:0] ra [10] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h0B, 8'h0C};
    logic [7:0] rv [10];
    logic [7:0] ex [10];

    brx_exec dut_u (.clk_in(clk_in), .resetn_in(resetn_in), .bus_req_in(bus_req), .bus_rdata_out(bus_rdata),
        .prog_data_in(prog_data), .prog_addr_out(prog_addr), .stack_top_in(stack_top), .stack_pop_out(stack_pop));
    brx_prog_model mdl_u (.clk_in(clk_in), .prog_addr_in(prog_addr), .prog_data_out(prog_data),
        .stack_pop_in(stack_pop), .stack_top_out(stack_top));

    // =====
    // clock and hang guard
    initial begin
        forever #5 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            stop_test();
        end
    end

    // =====
    // shared tasks
    task check(input string what, input logic [20:0] seen, input logic [20:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task stop_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test
    // memory is cleared inside reset so no stale word is ever fetched
    task start();
        resetn_in <= 1'b0;
        mdl_u.clear_all();
        repeat (10) @(posedge clk_in);
        resetn_in <= 1'b1;
    endtask : start
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        bus_req <= {a, d, 2'b10};
        @(posedge clk_in);
        bus_req <= '0;
    endtask : wr
    task rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk_in);
        bus_req <= {a, 8'h00, 2'b01};
        @(posedge clk_in);
        bus_req <= '0;
        #1 v = bus_rdata;
    endtask : rd
    // returns one step after the decode edge of the word at 0x80
    task wait_pc();
        for (int k = 0; k < 400 && prog_addr !== 21'h000082; k++) begin
            @(posedge clk_in);
            #1;
        end
    endtask : wait_pc

    // =====
    // scenarios
    task run_regs();
        logic [7:0] a [8];
        logic [7:0] e [8];
        logic [7:0] v;
        a = '{8'h01, 8'h03, 8'h0F, 8'h10, 8'h0B, 8'h0C, 8'h12, 8'h40};
        e = '{8'h1F, 8'h0F, 8'h1F, 8'hFF, 8'hFF, 8'h1F, 8'h0F, 8'h00};
        start();
        for (int i = 0; i < 8; i++) begin
            rd(a[i], v);
            check("reset value", 21'(v), 21'h0);
            wr(a[i], 8'hFF);
            rd(a[i], v);
            check("field width", 21'(v), 21'(e[i]));
        end
        $display("test regs done");
    endtask : run_regs

    // a literal return follows the branch: it must vanish when taken
    task run_branch(input logic [3:0] cc, input logic [4:0] st, input logic [7:0] n, input logic take);
        logic [20:0] tgt;
        logic [7:0] v;
        tgt = 21'h000082 + {{12{n[7]}}, n, 1'b0};
        start();
        mdl_u.mem[8'h40] = {4'hE, cc, n};
        mdl_u.mem[8'h41] = 16'h0C5A;
        mdl_u.stk[0] = 21'h00A5C4;
        mdl_u.sp = 3'h1;
        wr(8'h01, {3'h0, st});
        wait_pc();
        repeat (4) @(posedge clk_in);
        #1 check("branch pc", prog_addr, take ? tgt : 21'h000084);
        repeat (4) @(posedge clk_in);
        #1 check("next pc", prog_addr, take ? tgt + 21'h000002 : 21'h00A5C4);
        rd(8'h02, v);
        check("work reg", 21'(v), take ? 21'h0 : 21'h5A);
        rd(8'h01, v);
        check("flags", 21'(v), 21'(st));
        $display("test branch %h done", cc);
    endtask : run_branch

    task run_interrupt_return_op(input logic s, input logic [1:0] ctl, input logic [7:0] ie, input logic [7:0] ie_exp);
        logic [7:0] v;
        start();
        mdl_u.mem[8'h40] = {15'h0008, s};
        mdl_u.stk[0] = 21'h01B2E6;
        mdl_u.sp = 3'h1;
        rv = '{{6'h0, ctl}, 8'h03, 8'h11, 8'h02, ie, 8'h99, 8'h1C, 8'h07, 8'h33, 8'h15};
        ex = rv;
        ex[1] = s ? 8'h1C : 8'h03;
        ex[2] = s ? 8'h99 : 8'h11;
        ex[3] = s ? 8'h07 : 8'h02;
        ex[4] = ie_exp;
        for (int i = 0; i < 10; i++) begin
            wr(ra[i], rv[i]);
        end
        wait_pc();
        repeat (3) @(posedge clk_in);
        #1 check("pop pulse", 21'(stack_pop), 21'h1);
        check("return pc", prog_addr, 21'h01B2E6);
        @(posedge clk_in);
        #1 check("pop ends", 21'(stack_pop), 21'h0);
        repeat (4) @(posedge clk_in);
        #1 check("pc after idle", prog_addr, 21'h01B2E8);
        for (int i = 1; i < 10; i++) begin
            rd(ra[i], v);
            check("restored reg", 21'(v), 21'(ex[i]));
        end
        $display("test int return %b done", s);
    endtask : run_interrupt_return_op

    // file bytes are not reset, so the target and the direct byte are preloaded
    task run_bitclr(input logic [7:0] f, input logic [1:0] ctl, input logic [11:0] loc);
        logic [7:0] v;
        start();
        mdl_u.mem[8'h40] = {4'h9, 3'h7, 1'b0, f};
        dut_u.u_rf.mem[loc] = 8'hC7;
        dut_u.u_rf.mem[{4'h0, f}] = 8'hC7;
        wr(8'h00, {6'h0, ctl});
        wr(8'h01, 8'h1F);
        wr(8'h11, 8'h10);
        wait_pc();
        repeat (4) @(posedge clk_in);
        #1 check("one cycle", prog_addr, 21'h000084);
        check("cleared byte", 21'(dut_u.u_rf.mem[loc]), 21'h47);
        check("direct byte", 21'(dut_u.u_rf.mem[{4'h0, f}]), (loc == {4'h0, f}) ? 21'h47 : 21'hC7);
        rd(8'h01, v);
        check("flags kept", 21'(v), 21'h1F);
        $display("test bit clear %h done", f);
    endtask : run_bitclr

    // =====
    // main sequence
    initial begin
        run_regs();
        run_branch(4'h6, 5'h10, 8'h05, 1'b1);
        run_branch(4'h6, 5'h0F, 8'h7F, 1'b0);
        run_branch(4'h5, 5'h17, 8'h80, 1'b1);
        run_branch(4'h5, 5'h08, 8'h10, 1'b0);
        run_branch(4'h1, 5'h1B, 8'h7F, 1'b1);
        run_branch(4'h1, 5'h04, 8'h01, 1'b0);
        run_interrupt_return_op(1'b1, 2'h0, 8'h00, 8'h80);
        run_interrupt_return_op(1'b0, 2'h2, 8'h80, 8'hC0);
        run_interrupt_return_op(1'b0, 2'h2, 8'h00, 8'h80);
        run_bitclr(8'h20, 2'h0, 12'h020);
        run_bitclr(8'h5F, 2'h1, 12'h06F);
        stop_test();
    end
endmodule : test_brx_exec
`default_nettype wire
